// file: hw/rom_pkg.sv
package rom_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int unsigned NUM_REGS       = 7;
    localparam int unsigned NUM_PINS       = 14;
    localparam int unsigned FIRST_PIN      = 18;
    localparam int unsigned SEL_W          = 6;
    localparam int unsigned NUM_FUNCS      = 64;
    localparam int unsigned REG_W          = 16;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int unsigned EVEN_LSB       = 0;
    localparam int unsigned ODD_LSB        = 8;
    localparam logic [15:0] IMPL_MASK      = 16'h3F3F;
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam logic [5:0]  SEL_RESET      = 6'h00;
    localparam logic [5:0]  SEL_NONE       = 6'h00;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0]  OFS_PINS_18_19 = 5'h00;
    localparam logic [4:0]  OFS_PINS_20_21 = 5'h04;
    localparam logic [4:0]  OFS_PINS_22_23 = 5'h08;
    localparam logic [4:0]  OFS_PINS_24_25 = 5'h0C;
    localparam logic [4:0]  OFS_PINS_26_27 = 5'h10;
    localparam logic [4:0]  OFS_PINS_28_29 = 5'h14;
    localparam logic [4:0]  OFS_PINS_30_31 = 5'h18;
    localparam int unsigned ADDR_W         = 5;

    // ----------------------------------------------------------------
    // Package variants
    // ----------------------------------------------------------------
    localparam logic [1:0]  PKG_64         = 2'h0;
    localparam logic [1:0]  PKG_80         = 2'h1;
    localparam logic [1:0]  PKG_100        = 2'h2;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } rom_wreq_s;

    typedef enum logic [0:0] {
        ROM_W_IDLE,
        ROM_W_RESP
    } rom_wstate_e;

endpackage : rom_pkg

// file: hw/rom_output_map.sv
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Each remap pin with a nonzero, defined select field carries the peripheral output numbered by that field, except pin 31 on 64 and 80 pin variants.
// - Odd pin select in bits 13-8, even pin select in bits 5-0.
// - Bits 15-14 and 7-6 ignore writes and read zero.
// - Select fields are read/write and reset to zero.
// - On 64 and 80 pin variants pin 31 select reads zero.
module rom_output_map
    import rom_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // Package variant strap, static after reset
    input  wire logic [1:0]           pkg_variant,
    // Peripheral outputs indexed by function number
    input  wire logic [NUM_FUNCS-1:0] periph_out,
    // Function numbers that exist on this device
    input  wire logic [NUM_FUNCS-1:0] func_defined,
    output logic      [NUM_PINS-1:0]  remap_pin_out,
    output logic      [NUM_PINS-1:0]  remap_pin_oe,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);

    // ----------------------------------------------------------------
    // Select storage
    // ----------------------------------------------------------------
    logic [SEL_W-1:0] pin_sel [NUM_PINS];
    logic             pin31_present;

    // ----------------------------------------------------------------
    // Variant capture
    // ----------------------------------------------------------------
    // Strap comes from a pin: three stages, accepted once stages 2 and 3 agree
    logic [1:0]       variant_s1;
    logic [1:0]       variant_s2;
    logic [1:0]       variant_s3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            variant_s1 <= PKG_64;
            variant_s2 <= PKG_64;
            variant_s3 <= PKG_64;
        end else begin
            variant_s1 <= pkg_variant;
            variant_s2 <= variant_s1;
            variant_s3 <= variant_s2;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin31_present <= 1'b0;
        end else if (variant_s2 == variant_s3) begin
            pin31_present <= (variant_s3 == PKG_100);
        end
    end

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    logic             aw_held;
    logic             w_held;
    rom_wreq_s        wreq;
    logic             do_write;
    logic             w_hit;
    logic [2:0]       w_idx;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        w_hit = (wreq.addr[1:0] == 2'h0) && (wreq.addr <= OFS_PINS_30_31);
        w_idx = wreq.addr[4:2];
    end

    // Request capture, one process for the whole struct
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreq <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wreq.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wreq.data <= s_axi_wdata;
                wreq.strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held       <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held       <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Select registers
    // ----------------------------------------------------------------
    // writable, reset zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                pin_sel[i] <= SEL_RESET;
            end
        end else if (do_write && w_hit) begin
            // even pin low byte, odd pin high byte
            if (wreq.strb[0]) begin
                pin_sel[{w_idx, 1'b0}] <= wreq.data[EVEN_LSB +: SEL_W];
            end
            if (wreq.strb[1]) begin
                pin_sel[{w_idx, 1'b1}] <= wreq.data[ODD_LSB +: SEL_W];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    logic [REG_W-1:0] rd_word;
    logic [2:0]       r_idx;
    logic             r_hit;
    logic [SEL_W-1:0] odd_sel;

    always_comb begin
        r_idx = s_axi_araddr[4:2];
        r_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= OFS_PINS_30_31);
        odd_sel = pin_sel[{r_idx, 1'b1}];
        // pin 31 absent on smaller variants
        if (({r_idx, 1'b1} == 4'(NUM_PINS - 1)) && !pin31_present) begin
            odd_sel = SEL_NONE;
        end
        rd_word = REG_RESET;
        if (r_hit) begin
            rd_word = ({2'b00, odd_sel, 2'b00, pin_sel[{r_idx, 1'b0}]}) & IMPL_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, rd_word};
            s_axi_rresp   <= r_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remap_pin_out <= '0;
            remap_pin_oe  <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                // zero or undefined leaves pin free
                if (pin_sel[p] != SEL_NONE && func_defined[pin_sel[p]]
                    && !(p == NUM_PINS - 1 && !pin31_present)) begin
                    remap_pin_out[p] <= periph_out[pin_sel[p]];
                    remap_pin_oe[p]  <= 1'b1;
                end else begin
                    remap_pin_out[p] <= 1'b0;
                    remap_pin_oe[p]  <= 1'b0;
                end
            end
        end
    end

endmodule : rom_output_map

// file: test/rom_output_map_sva.sv
`timescale 1ns/1ps
module rom_output_map_sva
    import rom_pkg::*;
(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic [1:0]           pkg_variant,
    input wire logic [NUM_FUNCS-1:0] periph_out,
    input wire logic [NUM_FUNCS-1:0] func_defined,
    input wire logic [NUM_PINS-1:0]  remap_pin_out,
    input wire logic [NUM_PINS-1:0]  remap_pin_oe,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic [1:0]           s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rdata_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFFC0C0) == 32'h0)
        else $error("reserved read bits set");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_reset_idle: assert property ($rose(aresetn) |-> remap_pin_oe == '0)
        else $error("pin driven after reset");
    a_route_low: assert property ((periph_out == '0) [*2] |=> remap_pin_out == '0)
        else $error("pin high with all sources low");
    a_oe_gate: assert property ((remap_pin_out & ~remap_pin_oe) == '0)
        else $error("pin data without enable");
    a_undef_off: assert property ((func_defined == '0) [*2] |=> remap_pin_oe == '0)
        else $error("pin driven by undefined source");
    a_pin31_gone: assert property ((pkg_variant != PKG_100) [*6] |-> !remap_pin_oe[NUM_PINS-1])
        else $error("absent pin driven");
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cover property (remap_pin_oe == 14'h3FFF);
    cover property (s_axi_arvalid && s_axi_arready);
endmodule : rom_output_map_sva

bind rom_output_map rom_output_map_sva u_sva (.*);

// file: test/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    import rom_pkg::*;
    localparam logic [63:0] PAT = 64'hA5A4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [1:0] pkg_variant = PKG_64;
    logic [63:0] periph_out = '0;
    logic [63:0] func_defined = '0;
    logic [13:0] remap_pin_out, remap_pin_oe;
    logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #12.5 aclk = ~aclk;

    rom_output_map u_dut (.*);

    task automatic stop_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic aw, w, b;
        logic [1:0] bresp_got;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            bresp_got = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
        `CHK(bresp_got, RESP_OKAY)
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        logic ar, r;
        logic [33:0] got;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            got = {s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!r);
        s_axi_rready <= 1'b0;
        `CHK(got, e)
    endtask : rd

    task automatic pins(input logic [13:0] eo, input logic [13:0] eoe);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(remap_pin_out, eo)
        `CHK(remap_pin_oe, eoe)
    endtask : pins

    task automatic t_reset;
        for (int i = 0; i < 7; i++) rd(5'(i * 4), 34'h0);
        rd(5'h1C, {RESP_SLVERR, 32'h0});
    endtask : t_reset

    task automatic t_fields;
        for (int i = 0; i < 7; i++) wr(5'(i * 4), 16'hFFFF);
        for (int v = 0; v < 3; v++) begin
            pkg_variant <= 2'(v);
            repeat (8) @(posedge aclk);
            for (int i = 0; i < 7; i++)
                rd(5'(i * 4), (i == 6 && v < 2) ? 34'h3F : 34'h3F3F);
        end
    endtask : t_fields

    task automatic t_route;
        func_defined <= ~64'h1;
        for (int i = 0; i < 7; i++) wr(5'(i * 4), 16'h0302 + 16'(i) * 16'h0202);
        periph_out <= PAT;
        pins(PAT[15:2], 14'h3FFF);
        periph_out <= ~PAT;
        pins(~PAT[15:2], 14'h3FFF);
        func_defined <= 64'hFFFF_FFFF_FFFF_FFF0;
        pkg_variant <= PKG_80;
        wr(5'h04, 16'h0000);
        pins(~PAT[15:2] & 14'h1FF0, 14'h1FF0);
    endtask : t_route

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fields();
        t_route();
        stop_test();
    end
endmodule : tb_top
